// ### shared/adc_window_defines.svh
// Register indices, field positions, reset values of the window comparator.
// Assumes byte address = index * 4 on a 32-bit APB bus.
`ifndef ADC_WINDOW_DEFINES_SVH
`define ADC_WINDOW_DEFINES_SVH

// Register indices
`define IDX_TRACK 10'h0BA
`define IDX_RESULT_LOW 10'h0BD
`define IDX_RESULT_HIGH 10'h0BE
`define IDX_UPPER_LOW 10'h0C3
`define IDX_UPPER_HIGH 10'h0C4
`define IDX_LOWER_LOW 10'h0C5
`define IDX_LOWER_HIGH 10'h0C6
`define IDX_CTRL 10'h0E8
`define IDX_IRQ_STATUS 10'h0F0
`define IDX_IRQ_MASK 10'h0F1

// Reset values
`define RST_TRACK 8'hFF
`define RST_CTRL 8'h00
`define RST_UPPER 16'hFFFF
`define RST_LOWER 16'h0000
`define RST_MASK 8'h00
`define RST_RESULT 16'h0000

// Control register bits
`define CTRL_EN_BIT 7
`define CTRL_BURST_BIT 6
`define CTRL_WIN_BIT 3
`define CTRL_LJST_BIT 2

// Tracking register fields
`define TRK_PWR_MSB 7
`define TRK_PWR_LSB 4
`define TRK_TM_MSB 3
`define TRK_TM_LSB 2
`define TRK_TK_MSB 1
`define TRK_TK_LSB 0

// Interrupt status bits
`define STAT_WIN_BIT 0
`define STAT_DONE_BIT 1
`define STAT_USED 8'h03

// Converter result width and left-justify padding
`define RES_BITS 12
`define RES_PAD 4

`endif

// ### shared/adc_window_pkg.sv
// Types shared by the window comparator design.
// Assumes nothing beyond a SystemVerilog compiler.
package adc_window_pkg;
  typedef logic [15:0] word_t;
  typedef logic [7:0] byte_t;
  // Which way the window flag reports
  typedef enum logic [1:0] {
    WIN_OUTSIDE = 2'b01,
    WIN_INSIDE = 2'b10
  } win_mode_t;
  // Placement of the converter result in the word
  typedef enum logic [1:0] {
    JUST_RIGHT = 2'b01,
    JUST_LEFT = 2'b10
  } just_t;
endpackage

// ### rtl/adc_window_cmp.sv
// Window comparator: one-cycle hit pulse per valid sample that meets the selected window condition.
// Assumes sample, limits and valid come from logic on clk_sys.
module adc_window_cmp #(
  parameter int WIDTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sample_valid,
  input wire logic [WIDTH-1:0] sample,
  input wire logic [WIDTH-1:0] upper,
  input wire logic [WIDTH-1:0] lower,
  output adc_window_pkg::win_mode_t mode,
  output logic hit_pulse
);
  import adc_window_pkg::*;

  logic hit_r;
  logic hit_nxt;
  logic in_win;
  logic out_win;

  generate
    if (WIDTH < 2)
    begin : g_bad_width
      $error("adc_window_cmp: WIDTH must be at least 2");
    end
  endgenerate

  // Mode follows the ordering of the two limits
  assign mode = (lower > upper) ? WIN_INSIDE : WIN_OUTSIDE;
  // Strictly between limits, equality excluded
  assign in_win = (sample > upper) && (sample < lower);
  // Below smaller bound or above larger bound
  assign out_win = (sample < lower) || (sample > upper);

  // Pulse on each new sample meeting the selected condition
  always_comb
  begin
    hit_nxt = 1'b0;
    if (sample_valid)
    begin
      unique case (mode)
        WIN_INSIDE: hit_nxt = in_win;
        WIN_OUTSIDE: hit_nxt = out_win;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      hit_r <= 1'b0;
    else
      hit_r <= hit_nxt;
  end

  assign hit_pulse = hit_r;
endmodule

// ### rtl/adc_window_compare.sv
// Converter window detector with APB register slave and interrupt.
// Assumes conversion results arrive on clk_sys with a one-cycle valid strobe.
// Functional notes
// - Every new result word is compared to both limits automatically and a match sets the flag.
// - Software can read the window flag, so it serves polling as well as interrupts.
// - Each limit is a 16-bit value held in a high-byte and a low-byte register.
// - Whether the flag means inside or outside the window follows only from the limit values.
// - Right-justified single-ended results compare as 12-bit unsigned numbers.
// - Inside detection needs the result strictly above the upper limit and below the lower one.
// - Outside detection needs the result strictly below the smaller or above the larger bound.
// - Left-justified results compare the same way, with limits in the same justification.
`include "adc_window_defines.svh"

module adc_window_compare #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  // APB slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter result
  input wire logic [`RES_BITS-1:0] conv_data,
  input wire logic conv_valid,
  // Controls toward the converter
  output logic converter_enable,
  output logic burst_mode_enable,
  output logic left_justify,
  output logic [3:0] burst_powerup_time,
  output logic [1:0] track_mode_field,
  output logic [1:0] post_track_time_field,
  // Status
  output logic window_hit_flag,
  output adc_window_pkg::win_mode_t window_mode,
  output logic irq
);
  import adc_window_pkg::*;

  // Refuse widths the fixed decode cannot serve
  generate
    if (ADDR_W < 12)
    begin : g_bad_addr
      $error("adc_window_compare: ADDR_W must be at least 12");
    end
    if (`RES_BITS + `RES_PAD != 16)
    begin : g_bad_result
      $error("adc_window_compare: result and padding must fill 16 bits");
    end
  endgenerate

  // Register index of a byte address
  function automatic logic [9:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[11:2];
  endfunction

  // True when the address selects the given register
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [9:0] idx);
    logic upper_zero;
    upper_zero = 1'b1;
    for (int i = 12; i < ADDR_W; i++)
    begin
      if (addr[i])
        upper_zero = 1'b0;
    end
    reg_hit = upper_zero && (addr[1:0] == 2'h0) && (reg_index(addr) == idx);
  endfunction

  // Register state
  byte_t track_r, track_nxt;
  byte_t ctrl_r, ctrl_nxt;
  word_t upper_r, upper_nxt;
  word_t lower_r, lower_nxt;
  word_t result_r, result_nxt;
  byte_t stat_r, stat_nxt;
  byte_t mask_r, mask_nxt;
  logic win_flag_r, win_flag_nxt;

  // Bus state
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  logic rd_stat_r, rd_stat_nxt;

  // Bus decode and datapath nets
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic mapped;
  byte_t rd_byte;
  byte_t wr_byte;
  word_t sample_word;
  logic hit_pulse;
  just_t just_sel;

  // APB phases, zero wait states
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign pready = access_ph;
  assign wr_en = access_ph && pwrite && pstrb[0] && !pslverr_r;
  assign wr_byte = pwdata[7:0];

  // Justification of the incoming result
  assign just_sel = ctrl_r[`CTRL_LJST_BIT] ? JUST_LEFT : JUST_RIGHT;

  // Result word as seen by software and the comparator
  always_comb
  begin
    sample_word = {{`RES_PAD{1'b0}}, conv_data};
    unique case (just_sel)
      JUST_RIGHT: sample_word = {{`RES_PAD{1'b0}}, conv_data};
      JUST_LEFT: sample_word = {conv_data, {`RES_PAD{1'b0}}};
    endcase
  end

  // Comparator on the live sample, hit one cycle after conv_valid
  adc_window_cmp #(
    .WIDTH(16)
  ) u_cmp (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .sample_valid(conv_valid),
    .sample(sample_word),
    .upper(upper_r),
    .lower(lower_r),
    .mode(window_mode),
    .hit_pulse(hit_pulse)
  );

  // Read multiplexer, decoded in the setup phase
  always_comb
  begin
    rd_byte = 8'h00;
    mapped = 1'b1;
    if (reg_hit(paddr, `IDX_TRACK))
      rd_byte = track_r;
    else if (reg_hit(paddr, `IDX_CTRL))
      rd_byte = ctrl_r | ({7'h00, win_flag_r} << `CTRL_WIN_BIT);
    else if (reg_hit(paddr, `IDX_RESULT_HIGH))
      rd_byte = result_r[15:8];
    else if (reg_hit(paddr, `IDX_RESULT_LOW))
      rd_byte = result_r[7:0];
    else if (reg_hit(paddr, `IDX_UPPER_HIGH))
      rd_byte = upper_r[15:8];
    else if (reg_hit(paddr, `IDX_UPPER_LOW))
      rd_byte = upper_r[7:0];
    else if (reg_hit(paddr, `IDX_LOWER_HIGH))
      rd_byte = lower_r[15:8];
    else if (reg_hit(paddr, `IDX_LOWER_LOW))
      rd_byte = lower_r[7:0];
    else if (reg_hit(paddr, `IDX_IRQ_STATUS))
      rd_byte = stat_r;
    else if (reg_hit(paddr, `IDX_IRQ_MASK))
      rd_byte = mask_r;
    else
      mapped = 1'b0;
  end

  // Bus answer captured at setup, held through the access phase
  always_comb
  begin
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    rd_stat_nxt = rd_stat_r;
    // Decode once, at the setup edge
    if (setup_ph)
    begin
      prdata_nxt = {24'h000000, rd_byte};
      pslverr_nxt = !mapped;
      rd_stat_nxt = !pwrite && reg_hit(paddr, `IDX_IRQ_STATUS);
    end
  end

  // Bus answer registers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
      rd_stat_r <= 1'b0;
    end
    else
    begin
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      rd_stat_r <= rd_stat_nxt;
    end
  end

  // Read data and error only while the access phase lasts
  assign prdata = access_ph ? prdata_r : 32'h00000000;
  assign pslverr = access_ph && pslverr_r;

  // Software-written registers
  always_comb
  begin
    track_nxt = track_r;
    ctrl_nxt = ctrl_r;
    upper_nxt = upper_r;
    lower_nxt = lower_r;
    mask_nxt = mask_r;
    if (wr_en)
    begin
      if (reg_hit(paddr, `IDX_TRACK))
        track_nxt = wr_byte;
      if (reg_hit(paddr, `IDX_CTRL))
      begin
        // Flag bit lives in its own register
        ctrl_nxt[`CTRL_EN_BIT] = wr_byte[`CTRL_EN_BIT];
        ctrl_nxt[`CTRL_BURST_BIT] = wr_byte[`CTRL_BURST_BIT];
        ctrl_nxt[`CTRL_LJST_BIT] = wr_byte[`CTRL_LJST_BIT];
      end
      if (reg_hit(paddr, `IDX_UPPER_HIGH))
        upper_nxt[15:8] = wr_byte;
      if (reg_hit(paddr, `IDX_UPPER_LOW))
        upper_nxt[7:0] = wr_byte;
      if (reg_hit(paddr, `IDX_LOWER_HIGH))
        lower_nxt[15:8] = wr_byte;
      if (reg_hit(paddr, `IDX_LOWER_LOW))
        lower_nxt[7:0] = wr_byte;
      if (reg_hit(paddr, `IDX_IRQ_MASK))
        mask_nxt = wr_byte & `STAT_USED;
    end
  end

  // Software register storage
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      track_r <= `RST_TRACK;
      ctrl_r <= `RST_CTRL;
      upper_r <= `RST_UPPER;
      lower_r <= `RST_LOWER;
      mask_r <= `RST_MASK;
    end
    else
    begin
      track_r <= track_nxt;
      ctrl_r <= ctrl_nxt;
      upper_r <= upper_nxt;
      lower_r <= lower_nxt;
      mask_r <= mask_nxt;
    end
  end

  // Latest result, window flag and sticky interrupt status
  always_comb
  begin
    result_nxt = result_r;
    win_flag_nxt = win_flag_r;
    stat_nxt = stat_r;
    // Every valid sample refreshes the result
    if (conv_valid)
      result_nxt = sample_word;
    // Writing zero clears the flag; a hit in the same cycle wins
    if (wr_en && reg_hit(paddr, `IDX_CTRL) && !wr_byte[`CTRL_WIN_BIT])
      win_flag_nxt = 1'b0;
    if (hit_pulse)
      win_flag_nxt = 1'b1;
    // Status read clears only the bits that were returned
    if (access_ph && rd_stat_r)
      stat_nxt = stat_r & ~prdata_r[7:0];
    if (hit_pulse)
      stat_nxt[`STAT_WIN_BIT] = 1'b1;
    if (conv_valid)
      stat_nxt[`STAT_DONE_BIT] = 1'b1;
  end

  // Result, flag and status storage
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      result_r <= `RST_RESULT;
      win_flag_r <= 1'b0;
      stat_r <= 8'h00;
    end
    else
    begin
      result_r <= result_nxt;
      win_flag_r <= win_flag_nxt;
      stat_r <= stat_nxt;
    end
  end

  // Outputs toward the converter and the processor
  assign converter_enable = ctrl_r[`CTRL_EN_BIT];
  assign burst_mode_enable = ctrl_r[`CTRL_BURST_BIT];
  assign left_justify = ctrl_r[`CTRL_LJST_BIT];
  assign burst_powerup_time = track_r[`TRK_PWR_MSB:`TRK_PWR_LSB];
  assign track_mode_field = track_r[`TRK_TM_MSB:`TRK_TM_LSB];
  assign post_track_time_field = track_r[`TRK_TK_MSB:`TRK_TK_LSB];
  assign window_hit_flag = win_flag_r;
  // Level request from unmasked sticky status
  assign irq = |(stat_r & mask_r);
endmodule

// ### sim/adc_window_monitor.sv
// Port checker for the window comparator.
// Assumes a bind onto adc_window_compare.
module adc_window_monitor #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conv_valid,
  input wire logic left_justify,
  input wire logic window_hit_flag,
  input wire adc_window_pkg::win_mode_t window_mode,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import adc_window_pkg::*;
  logic acc;
  logic rd;
  // Access and read phase decode
  assign acc = psel && penable;
  assign rd = acc && !pwrite;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_ready; pready == acc; endproperty
  a_ready: assert property (p_ready) else $error("ready wrong");
  property p_mode; window_mode inside {WIN_INSIDE, WIN_OUTSIDE}; endproperty
  a_mode: assert property (p_mode) else $error("mode code");
  property p_cause; $rose(window_hit_flag) |-> $past(conv_valid, 2); endproperty
  a_cause: assert property (p_cause) else $error("flag without sample");
  property p_hold; window_hit_flag && !(acc && pwrite) |=> window_hit_flag; endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  // Mask write shows on irq one edge after its access edge
  property p_irq;
    $rose(irq) |-> $past(conv_valid) || $past(conv_valid, 2) || $past(acc && pwrite);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
  property p_err; acc && paddr[1:0] != 2'b00 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_right;
    rd && paddr == 12'h2F8 && !left_justify |-> prdata[31:4] == 28'h0;
  endproperty
  a_right: assert property (p_right) else $error("right pad");
  property p_left; rd && paddr == 12'h2F4 && left_justify |-> prdata[3:0] == 4'h0; endproperty
  a_left: assert property (p_left) else $error("left pad");
  c_hit: cover property ($rose(window_hit_flag));
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
endmodule

// ### sim/conv_model.sv
// Converter result source.
// Assumes clk_sys from the bench.
module conv_model (
  input wire logic clk_sys,
  output logic [11:0] conv_data,
  output logic conv_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    conv_data = 12'h000;
    conv_valid = 1'b0;
  end
  // One-cycle strobe, data scrambled after it
  task automatic send(input logic [11:0] d);
    @(posedge clk_sys);
    conv_data <= d;
    conv_valid <= 1'b1;
    @(posedge clk_sys);
    conv_valid <= 1'b0;
    conv_data <= ~d;
  endtask
endmodule

// ### sim/testbench.sv
// Self-checking bench for the window comparator.
// Assumes package, defines, design, checker and converter model.
`include "adc_window_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_window_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [3:0] pstrb = 4'hF, burst_powerup_time;
  logic pready, pslverr, conv_valid, converter_enable, burst_mode_enable, left_justify;
  logic window_hit_flag, irq, erv;
  logic [11:0] conv_data;
  logic [1:0] track_mode_field, post_track_time_field, offs = 2'b00;
  logic [15:0] upv, lov;
  win_mode_t window_mode;
  logic [11:0] smp [6] = '{12'h0FF, 12'h100, 12'h101, 12'h1FF, 12'h200, 12'h201};
  int err_total = 0;
  int num_checks = 0;
  adc_window_compare u_dut (.clk_sys, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .conv_data, .conv_valid, .converter_enable,
    .burst_mode_enable, .left_justify, .burst_powerup_time, .track_mode_field,
    .post_track_time_field, .window_hit_flag, .window_mode, .irq);
  conv_model u_conv (.clk_sys, .conv_data, .conv_valid);
  // Clock
  always #5 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // APB transfer, held until pready
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, offs};
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic lim(input logic [15:0] u, input logic [15:0] l);
    upv = u;
    lov = l;
    apb(1'b1, `IDX_UPPER_LOW, u[7:0]);
    apb(1'b1, `IDX_UPPER_HIGH, u[15:8]);
    apb(1'b1, `IDX_LOWER_LOW, l[7:0]);
    apb(1'b1, `IDX_LOWER_HIGH, l[15:8]);
    @(posedge clk_sys);
    chk("mode", 32'(window_mode), l > u ? 32'(WIN_INSIDE) : 32'(WIN_OUTSIDE));
  endtask
  // One sample: flag, irq, result, status, then clear
  task automatic try(input logic [11:0] s, input logic lj);
    logic [15:0] w;
    logic e;
    logic [7:0] hi;
    w = lj ? {s, 4'h0} : {4'h0, s};
    e = lov > upv ? (w > upv && w < lov) : (w < lov || w > upv);
    u_conv.send(s);
    repeat (2) @(posedge clk_sys);
    chk("flag", 32'(window_hit_flag), 32'(e));
    chk("irq", 32'(irq), 32'(e));
    apb(1'b0, `IDX_RESULT_HIGH, 8'h00);
    hi = rdv[7:0];
    apb(1'b0, `IDX_RESULT_LOW, 8'h00);
    chk("result", {16'h0, hi, rdv[7:0]}, 32'(w));
    apb(1'b0, `IDX_IRQ_STATUS, 8'h00);
    chk("status", rdv, {30'h0, 1'b1, e});
    apb(1'b1, `IDX_CTRL, {5'h0, lj, 2'b00});
    @(posedge clk_sys);
    chk("clear", 32'(window_hit_flag), 32'h0);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    apb(1'b0, `IDX_TRACK, 8'h00);
    chk("track", rdv, 32'h0000_00FF);
    chk("fields", {burst_powerup_time, track_mode_field, post_track_time_field}, 32'hFF);
    apb(1'b1, `IDX_TRACK, 8'h5A);
    apb(1'b0, `IDX_TRACK, 8'h00);
    chk("track_rw", rdv, 32'h5A);
    offs = 2'b10;
    apb(1'b0, `IDX_TRACK, 8'h00);
    chk("unmapped", 32'(erv), 32'h1);
    offs = 2'b00;
    apb(1'b1, `IDX_IRQ_MASK, 8'h01);
    lim(16'h0100, 16'h0200);
    foreach (smp[i])
      try(smp[i], 1'b0);
    lim(16'h0200, 16'h0100);
    foreach (smp[i])
      try(smp[i], 1'b0);
    // Enable, burst and left justify set, seen on pins and read back
    apb(1'b1, `IDX_CTRL, 8'hC4);
    @(posedge clk_sys);
    chk("ctrl_out", {converter_enable, burst_mode_enable, left_justify}, 32'h7);
    apb(1'b0, `IDX_CTRL, 8'h00);
    chk("ctrl_rd", rdv, 32'hC4);
    lim(16'h1000, 16'h2000);
    foreach (smp[i])
      try(smp[i], 1'b1);
    apb(1'b1, `IDX_IRQ_MASK, 8'h00);
    u_conv.send(12'h101);
    u_conv.send(12'h300);
    repeat (2) @(posedge clk_sys);
    chk("sticky", 32'(window_hit_flag), 32'h1);
    chk("masked", 32'(irq), 32'h0);
    apb(1'b0, `IDX_CTRL, 8'h00);
    chk("ctrl_flag", rdv, 32'h0C);
    // Unmasking a pending done bit raises irq
    apb(1'b1, `IDX_IRQ_MASK, 8'h02);
    @(posedge clk_sys);
    chk("irq_done", 32'(irq), 32'h1);
    // Second reset in mid-run
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    chk("rst_flag", 32'(window_hit_flag), 32'h0);
    chk("rst_irq", 32'(irq), 32'h0);
    apb(1'b0, `IDX_UPPER_HIGH, 8'h00);
    chk("rst_upper", rdv, 32'hFF);
    stop_test();
  end
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    stop_test();
  end
endmodule
bind adc_window_compare adc_window_monitor #(.ADDR_W(ADDR_W)) u_mon (.clk_sys, .rst_b,
  .paddr, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .conv_valid, .left_justify,
  .window_hit_flag, .window_mode, .irq);
